// >>> rtl/clk_ctl_pkg.sv
package clk_ctl_pkg;

  // ----------------------------------------
  // Control byte offsets (SMBus command codes)
  // ----------------------------------------
  localparam logic [7:0] REG_REC_N = 8'h0b;
  localparam logic [7:0] REG_REC_SEL_M = 8'h0c;
  localparam logic [7:0] REG_PROG_N = 8'h0d;
  localparam logic [7:0] REG_PROG_M = 8'h0e;
  localparam logic [7:0] REG_CTRL = 8'h0f;
  localparam logic [7:0] REG_SEL = 8'h10;

  // ----------------------------------------
  // Field widths and positions
  // ----------------------------------------
  localparam int N_W = 8;
  localparam int M_W = 7;
  localparam int SEL_W = 5;
  localparam int REC_SEL_BIT = 7;
  localparam int PROG_EN_BIT = 7;
  localparam int CTRL_OVR_BIT = 7;
  localparam int CTRL_RST_EN_BIT = 4;
  localparam int CTRL_TO_BIT = 2;
  localparam int CTRL_WATCHDOG_ENABLE_BIT = 1;

  // ----------------------------------------
  // Reset values and bus constants
  // ----------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [N_W-1:0] N_RESET = 8'h00;
  localparam logic [M_W-1:0] M_RESET = 7'h00;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
  // Arbitrary slave address, not tied to any real part
  localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h5a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DATA,
    ST_READ,
    ST_RACK
  } smb_state_t;

endpackage

// >>> rtl/clk_freq_ctl.sv
// Behaviour
// - Recovery N/M used when select is one
// - Select zero picks strap latch, one N/M
// - Time-out switches output to recovery automatically
// - Ratio from strap or software per override
// - Programmable enable applies programmed N/M
// - Writing programmed M starts frequency load
// - Zero count sets flag if watchdog enabled; reset if enabled
// - Lock after time-out until enable cleared
`timescale 1ns/1ps
module clk_freq_ctl #(
  parameter logic [6:0] SLAVE_ADDR = clk_ctl_pkg::SMB_ADDR_DEFAULT
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [clk_ctl_pkg::SEL_W-1:0] strap_frequency_selection_i,
  input wire logic watchdog_zero_i,
  output logic [clk_ctl_pkg::N_W-1:0] cpu_n_o,
  output logic [clk_ctl_pkg::M_W-1:0] cpu_m_o,
  output logic cpu_use_nm_o,
  output logic [clk_ctl_pkg::SEL_W-1:0] cpu_table_sel_o,
  output logic [clk_ctl_pkg::SEL_W-1:0] ratio_sel_o,
  output logic freq_load_o,
  output logic recovery_mode_o,
  output logic system_reset_o,
  output logic watchdog_enable_o,
  output logic watchdog_timeout_flag_o
);
  import clk_ctl_pkg::*;

  reg_access_if bus ();

  // ----------------------------------------
  // Control byte state
  // ----------------------------------------
  logic [N_W-1:0] rec_n_q, rec_n_d, prog_n_q, prog_n_d;
  logic [M_W-1:0] rec_m_q, rec_m_d, prog_m_q, prog_m_d;
  logic rec_sel_q, rec_sel_d, prog_en_q, prog_en_d;
  logic ovr_q, ovr_d, rst_en_q, rst_en_d, watchdog_enable_q, watchdog_enable_d;
  logic to_flag_q, to_flag_d, lock_q, lock_d;
  logic [SEL_W-1:0] sw_sel_q, sw_sel_d;
  logic [SEL_W-1:0] strap_s1_q, strap_s1_d, strap_s2_q, strap_s2_d;
  logic [SEL_W-1:0] strap_q, strap_d;
  logic strap_done_q, strap_done_d;
  logic [N_W-1:0] cpu_n_q, cpu_n_d;
  logic [M_W-1:0] cpu_m_q, cpu_m_d;
  logic use_nm_q, use_nm_d, load_q, load_d, sysrst_q, sysrst_d;
  logic [N_W-1:0] app_n_q, app_n_d;
  logic [M_W-1:0] app_m_q, app_m_d;
  logic app_en_q, app_en_d;
  logic [SEL_W-1:0] tab_q, tab_d, ratio_q, ratio_d;
  logic timeout, freq_wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_off);
    hit = (a == reg_off);
  endfunction

  smb_byte_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_smb (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .bus(bus.engine)
  );

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always_comb begin
    if (hit(bus.addr, REG_REC_N)) begin
      bus.rdata = rec_n_q;
    end else if (hit(bus.addr, REG_REC_SEL_M)) begin
      bus.rdata = {rec_sel_q, rec_m_q};
    end else if (hit(bus.addr, REG_PROG_N)) begin
      bus.rdata = prog_n_q;
    end else if (hit(bus.addr, REG_PROG_M)) begin
      bus.rdata = {prog_en_q, prog_m_q};
    end else if (hit(bus.addr, REG_CTRL)) begin
      bus.rdata = {ovr_q, 2'b00, rst_en_q, 1'b0, to_flag_q, watchdog_enable_q, 1'b0};
    end else if (hit(bus.addr, REG_SEL)) begin
      bus.rdata = {3'b000, sw_sel_q};
    end else begin
      bus.rdata = BYTE_RESET;
    end
  end

  // ----------------------------------------
  // Control byte writes and watchdog events
  // ----------------------------------------
  // A stopped watchdog cannot expire, so stray zero pulses are ignored
  assign timeout = watchdog_zero_i & watchdog_enable_q;
  // Frequency bytes are frozen while recovery holds the lock
  assign freq_wr = bus.wr & ~lock_q;

  always_comb begin
    rec_n_d = rec_n_q;
    rec_m_d = rec_m_q;
    rec_sel_d = rec_sel_q;
    prog_n_d = prog_n_q;
    prog_m_d = prog_m_q;
    prog_en_d = prog_en_q;
    ovr_d = ovr_q;
    rst_en_d = rst_en_q;
    watchdog_enable_d = watchdog_enable_q;
    sw_sel_d = sw_sel_q;
    to_flag_d = to_flag_q;
    lock_d = lock_q;
    app_n_d = app_n_q;
    app_m_d = app_m_q;
    app_en_d = app_en_q;
    load_d = 1'b0;
    if (freq_wr && hit(bus.addr, REG_REC_N)) begin
      rec_n_d = bus.wdata;
    end else if (freq_wr && hit(bus.addr, REG_REC_SEL_M)) begin
      rec_sel_d = bus.wdata[REC_SEL_BIT];
      rec_m_d = bus.wdata[M_W-1:0];
    end else if (freq_wr && hit(bus.addr, REG_PROG_N)) begin
      prog_n_d = bus.wdata;
    end else if (freq_wr && hit(bus.addr, REG_PROG_M)) begin
      prog_en_d = bus.wdata[PROG_EN_BIT];
      prog_m_d = bus.wdata[M_W-1:0];
      // The pair in use only moves here, so a lone N write cannot glitch the output
      app_en_d = bus.wdata[PROG_EN_BIT];
      app_n_d = prog_n_q;
      app_m_d = bus.wdata[M_W-1:0];
      load_d = 1'b1;
    end else if (freq_wr && hit(bus.addr, REG_SEL)) begin
      sw_sel_d = bus.wdata[SEL_W-1:0];
    end else if (bus.wr && hit(bus.addr, REG_CTRL)) begin
      rst_en_d = bus.wdata[CTRL_RST_EN_BIT];
      watchdog_enable_d = bus.wdata[CTRL_WATCHDOG_ENABLE_BIT];
      if (!lock_q) begin
        ovr_d = bus.wdata[CTRL_OVR_BIT];
      end
      if (bus.wdata[CTRL_TO_BIT]) begin
        to_flag_d = 1'b0;
      end
      if (!bus.wdata[CTRL_WATCHDOG_ENABLE_BIT]) begin
        lock_d = 1'b0;
      end
    end
    // Time-out wins over a clear landing in the same cycle
    if (timeout) begin
      to_flag_d = 1'b1;
      lock_d = 1'b1;
      load_d = 1'b1;
    end
  end

  // ----------------------------------------
  // Strap latch and frequency selection
  // ----------------------------------------
  always_comb begin
    strap_s1_d = strap_frequency_selection_i;
    strap_s2_d = strap_s1_q;
    strap_d = strap_q;
    strap_done_d = 1'b1;
    // Straps are caught once, the first cycle after reset release
    if (!strap_done_q) begin
      strap_d = strap_s2_q;
    end
    sysrst_d = timeout & rst_en_q;
    ratio_d = ovr_q ? sw_sel_q : strap_q;
    tab_d = strap_q;
    cpu_n_d = N_RESET;
    cpu_m_d = M_RESET;
    use_nm_d = 1'b0;
    if (lock_q) begin
      if (rec_sel_q) begin
        use_nm_d = 1'b1;
        cpu_n_d = rec_n_q;
        cpu_m_d = rec_m_q;
      end
    end else if (app_en_q) begin
      use_nm_d = 1'b1;
      cpu_n_d = app_n_q;
      cpu_m_d = app_m_q;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rec_n_q <= N_RESET;
      rec_m_q <= M_RESET;
      rec_sel_q <= 1'b0;
      prog_n_q <= N_RESET;
      prog_m_q <= M_RESET;
      prog_en_q <= 1'b0;
      ovr_q <= 1'b0;
      rst_en_q <= 1'b0;
      watchdog_enable_q <= 1'b0;
      sw_sel_q <= SEL_RESET;
      to_flag_q <= 1'b0;
      lock_q <= 1'b0;
      load_q <= 1'b0;
      app_n_q <= N_RESET;
      app_m_q <= M_RESET;
      app_en_q <= 1'b0;
      strap_q <= SEL_RESET;
      strap_done_q <= 1'b0;
      sysrst_q <= 1'b0;
      ratio_q <= SEL_RESET;
      tab_q <= SEL_RESET;
      cpu_n_q <= N_RESET;
      cpu_m_q <= M_RESET;
      use_nm_q <= 1'b0;
    end else begin
      rec_n_q <= rec_n_d;
      rec_m_q <= rec_m_d;
      rec_sel_q <= rec_sel_d;
      prog_n_q <= prog_n_d;
      prog_m_q <= prog_m_d;
      prog_en_q <= prog_en_d;
      ovr_q <= ovr_d;
      rst_en_q <= rst_en_d;
      watchdog_enable_q <= watchdog_enable_d;
      sw_sel_q <= sw_sel_d;
      to_flag_q <= to_flag_d;
      lock_q <= lock_d;
      load_q <= load_d;
      app_n_q <= app_n_d;
      app_m_q <= app_m_d;
      app_en_q <= app_en_d;
      strap_q <= strap_d;
      strap_done_q <= strap_done_d;
      sysrst_q <= sysrst_d;
      ratio_q <= ratio_d;
      tab_q <= tab_d;
      cpu_n_q <= cpu_n_d;
      cpu_m_q <= cpu_m_d;
      use_nm_q <= use_nm_d;
    end
  end

  // Strap synchroniser runs through reset, so the latch sees settled pins at release
  always_ff @(posedge mclk_i) begin
    strap_s1_q <= strap_s1_d;
    strap_s2_q <= strap_s2_d;
  end

  assign sda_o = 1'b0;
  assign cpu_n_o = cpu_n_q;
  assign cpu_m_o = cpu_m_q;
  assign cpu_use_nm_o = use_nm_q;
  assign cpu_table_sel_o = tab_q;
  assign ratio_sel_o = ratio_q;
  assign freq_load_o = load_q;
  assign recovery_mode_o = lock_q;
  assign system_reset_o = sysrst_q;
  assign watchdog_enable_o = watchdog_enable_q;
  assign watchdog_timeout_flag_o = to_flag_q;
endmodule

// >>> rtl/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport engine (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface

// >>> rtl/smb_byte_slave.sv
`timescale 1ns/1ps
module smb_byte_slave #(
  parameter logic [6:0] SLAVE_ADDR = clk_ctl_pkg::SMB_ADDR_DEFAULT
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  reg_access_if.engine bus
);
  import clk_ctl_pkg::*;

  smb_state_t state_q, state_d;
  logic scl_s1_q, scl_s1_d, scl_s2_q, scl_s2_d, scl_p_q, scl_p_d;
  logic sda_s1_q, sda_s1_d, sda_s2_q, sda_s2_d, sda_p_q, sda_p_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic ack_q, ack_d, oe_q, oe_d, wr_q, wr_d;
  logic rise, fall, start, stop;

  // --------------------------------
  // Pin synchronisers and edges
  // --------------------------------
  assign rise = scl_s2_q & ~scl_p_q;
  assign fall = ~scl_s2_q & scl_p_q;
  assign start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  always_comb begin
    scl_s1_d = scl_i;
    scl_s2_d = scl_s1_q;
    scl_p_d = scl_s2_q;
    sda_s1_d = sda_i;
    sda_s2_d = sda_s1_q;
    sda_p_d = sda_s2_q;
    state_d = state_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    ack_d = ack_q;
    oe_d = oe_q;
    wr_d = 1'b0;
    if (stop) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
      ack_d = 1'b0;
    end else if (start) begin
      // Repeated start keeps the command pointer for a byte read
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
      ack_d = 1'b0;
    end else if (rise) begin
      if (state_q == ST_READ) begin
        cnt_d = cnt_q + 4'h1;
      end else if (state_q == ST_RACK) begin
        if (sda_s2_q) begin
          state_d = ST_IDLE;
        end else begin
          ptr_d = ptr_q + 8'h01;
        end
      end else if (state_q != ST_IDLE && !ack_q) begin
        sh_d = {sh_q[6:0], sda_s2_q};
        cnt_d = cnt_q + 4'h1;
      end
    end else if (fall) begin
      if (ack_q) begin
        ack_d = 1'b0;
        oe_d = 1'b0;
        cnt_d = 4'h0;
        if (state_q == ST_ADDR && sh_q[0]) begin
          state_d = ST_READ;
          sh_d = bus.rdata;
          oe_d = ~bus.rdata[7];
        end else if (state_q == ST_ADDR) begin
          state_d = ST_CMD;
        end else begin
          state_d = ST_DATA;
        end
      end else if (state_q == ST_READ) begin
        if (cnt_q == BITS_PER_BYTE) begin
          oe_d = 1'b0;
          state_d = ST_RACK;
        end else begin
          sh_d = {sh_q[6:0], 1'b0};
          oe_d = ~sh_q[6];
        end
      end else if (state_q == ST_RACK) begin
        state_d = ST_READ;
        cnt_d = 4'h0;
        sh_d = bus.rdata;
        oe_d = ~bus.rdata[7];
      end else if (state_q != ST_IDLE && cnt_q == BITS_PER_BYTE) begin
        if (state_q == ST_ADDR && sh_q[7:1] != SLAVE_ADDR) begin
          state_d = ST_IDLE;
        end else begin
          ack_d = 1'b1;
          oe_d = 1'b1;
          if (state_q == ST_CMD) begin
            ptr_d = sh_q;
          end else if (state_q == ST_DATA) begin
            wr_d = 1'b1;
          end
        end
      end
    end
    // Block writes advance the pointer after each stored byte
    if (wr_q) begin
      ptr_d = ptr_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
      state_q <= ST_IDLE;
      sh_q <= BYTE_RESET;
      ptr_q <= BYTE_RESET;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      scl_s1_q <= scl_s1_d;
      scl_s2_q <= scl_s2_d;
      scl_p_q <= scl_p_d;
      sda_s1_q <= sda_s1_d;
      sda_s2_q <= sda_s2_d;
      sda_p_q <= sda_p_d;
      state_q <= state_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
    end
  end

  assign sda_oe_o = oe_q;
  assign bus.wr = wr_q;
  assign bus.addr = ptr_q;
  assign bus.wdata = sh_q;
endmodule

// >>> sim/clk_freq_ctl_asserts.sv
`timescale 1ns/1ps
module clk_freq_ctl_asserts (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic watchdog_zero_i,
  input wire logic [clk_ctl_pkg::N_W-1:0] cpu_n_o,
  input wire logic [clk_ctl_pkg::M_W-1:0] cpu_m_o,
  input wire logic cpu_use_nm_o,
  input wire logic [clk_ctl_pkg::SEL_W-1:0] cpu_table_sel_o,
  input wire logic [clk_ctl_pkg::SEL_W-1:0] ratio_sel_o,
  input wire logic freq_load_o,
  input wire logic recovery_mode_o,
  input wire logic system_reset_o,
  input wire logic watchdog_enable_o,
  input wire logic watchdog_timeout_flag_o
);
  import clk_ctl_pkg::*;
  // ----------------------------------------
  // Output timing checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic to_hit;
  assign to_hit = watchdog_zero_i && watchdog_enable_o;
  property p_to; to_hit |=> watchdog_timeout_flag_o && recovery_mode_o && freq_load_o; endproperty
  a_to: assert property (p_to) else $error("time-out effects missing");
  property p_flag; $rose(watchdog_timeout_flag_o) |-> $past(to_hit); endproperty
  a_flag: assert property (p_flag) else $error("flag without time-out");
  property p_rst; system_reset_o |-> $past(to_hit) && watchdog_timeout_flag_o; endproperty
  a_rst: assert property (p_rst) else $error("reset without time-out");
  property p_rst1; system_reset_o |=> !system_reset_o; endproperty
  a_rst1: assert property (p_rst1) else $error("reset pulse too long");
  // Two cycles of slack let the recovery choice land before it is frozen
  property p_lock;
    recovery_mode_o && $past(recovery_mode_o, 2) |->
      $stable({cpu_n_o, cpu_m_o, cpu_use_nm_o, ratio_sel_o});
  endproperty
  a_lock: assert property (p_lock) else $error("output moved while locked");
  property p_load;
    $changed({cpu_n_o, cpu_m_o, cpu_use_nm_o}) && !$past(recovery_mode_o) &&
      !$past(recovery_mode_o, 2) |-> $past(freq_load_o);
  endproperty
  a_load: assert property (p_load) else $error("frequency moved without load");
  property p_load1; freq_load_o |=> !freq_load_o; endproperty
  a_load1: assert property (p_load1) else $error("load pulse too long");
  property p_strap; $changed(cpu_table_sel_o) |-> !$past(resetn_i, 4); endproperty
  a_strap: assert property (p_strap) else $error("strap latch moved");
  c_rst: cover property (system_reset_o);
  c_load: cover property (freq_load_o && !recovery_mode_o);
  c_rec: cover property ($rose(recovery_mode_o));
endmodule

// >>> sim/smb_host_model.sv
`timescale 1ns/1ps
module smb_host_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ----------------------------------------
  // Phases of 10 clocks, well over the 4 clock minimum
  // ----------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic lv(input logic c, input logic d);
    scl_o = c;
    sda_low_o = !d;
    repeat (10) @(negedge mclk_i);
  endtask
  task automatic bit_x(input logic b, output logic r);
    lv(1'b0, b);
    lv(1'b1, b);
    r = sda_i;
    lv(1'b0, b);
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, a);
  endtask
  task automatic start_c();
    lv(scl_o, 1'b1);
    lv(1'b1, 1'b1);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
  endtask
  task automatic stop_c();
    lv(1'b0, 1'b0);
    lv(1'b1, 1'b0);
    lv(1'b1, 1'b1);
  endtask
  task automatic write_reg(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start_c();
    byte_x({ad, 1'b0}, q, a0);
    byte_x(c, q, a1);
    byte_x(d, q, a2);
    stop_c();
    ok = !(a0 | a1 | a2);
  endtask
  // Single byte read ends with a not-acknowledge
  task automatic read_reg(input logic [7:0] c, output logic [7:0] d);
    logic a;
    start_c();
    byte_x({ADDR, 1'b0}, d, a);
    byte_x(c, d, a);
    start_c();
    byte_x({ADDR, 1'b1}, d, a);
    byte_x(8'hff, d, a);
    stop_c();
  endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); \
  end \
end
module tb;
  import clk_ctl_pkg::*;
  logic mclk, resetn, wd_zero, scl, host_low, sda_oe, ok, nm;
  logic [4:0] strap;
  logic [7:0] n_o;
  logic [6:0] m_o;
  logic [4:0] tsel_o, ratio_o;
  logic load_o, rec_o, rst_o, en_o, flag_o;
  wire sda_w = !(host_low | sda_oe);
  int mismatches, n_compared, seed, rec, flag, ln, lm, e_load, e_rst, n_load, n_rst;
  int mr[6];
  logic [31:0] r;
  clk_freq_ctl dut_u (.mclk_i(mclk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .strap_frequency_selection_i(strap), .watchdog_zero_i(wd_zero),
    .cpu_n_o(n_o), .cpu_m_o(m_o), .cpu_use_nm_o(nm), .cpu_table_sel_o(tsel_o),
    .ratio_sel_o(ratio_o), .freq_load_o(load_o), .recovery_mode_o(rec_o),
    .system_reset_o(rst_o), .watchdog_enable_o(en_o), .watchdog_timeout_flag_o(flag_o));
  smb_host_model #(.ADDR(SMB_ADDR_DEFAULT)) host_u (.mclk_i(mclk), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(host_low));
  // ----------------------------------------
  // Reference model and checks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (load_o === 1'b1) n_load++;
    if (rst_o === 1'b1) n_rst++;
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] c, input logic [7:0] d);
    host_u.write_reg(SMB_ADDR_DEFAULT, c, d, ok);
    `CHK("ack", 1'b1, ok)
    if (c == REG_CTRL) begin
      mr[4] = rec ? (mr[4] & 8'h80) | (d & 8'h12) : d & 8'h92;
      if (!d[CTRL_WATCHDOG_ENABLE_BIT]) rec = 0;
      if (d[CTRL_TO_BIT]) flag = 0;
    end else if (!rec && c >= REG_REC_N && c <= REG_SEL) mr[c - REG_REC_N] = d;
    if (!rec && c == REG_PROG_M) begin
      ln = mr[2];
      lm = d;
      e_load++;
    end
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    host_u.read_reg(c, d);
    `CHK("read", e, d)
  endtask
  task automatic chk_outs();
    int en, n, m;
    en = rec ? mr[1][7] : lm[7];
    n = rec ? mr[0] : ln;
    m = rec ? mr[1] & 8'h7f : lm & 8'h7f;
    `CHK("use_nm", en[0], nm)
    `CHK("n", en ? n[7:0] : 8'h00, n_o)
    if (en) `CHK("m", m[6:0], m_o)
    `CHK("tsel", strap ^ 5'h15, tsel_o)
    `CHK("ratio", mr[4][7] ? mr[5][4:0] : strap ^ 5'h15, ratio_o)
    `CHK("rec", rec[0], rec_o)
    `CHK("flag", flag[0], flag_o)
    `CHK("watchdog_enable", mr[4][1], en_o)
    `CHK("loads", e_load, n_load)
    `CHK("resets", e_rst, n_rst)
  endtask
  task automatic wd_pulse();
    @(negedge mclk) wd_zero = 1'b1;
    @(negedge mclk) wd_zero = 1'b0;
    if (mr[4][1]) begin
      rec = 1;
      flag = 1;
      e_load++;
      e_rst += mr[4][4];
    end
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    seed = 32'h100b;
    resetn = 1'b0;
    wd_zero = 1'b0;
    strap = $random(seed);
    repeat (8) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    // The model expects the latched value, so the pins now move away from it
    strap = strap ^ 5'h15;
    chk_outs();
    for (int i = 0; i < 3; i++) rd_chk(REG_REC_N + i, 8'h00);
    rd_chk(8'h3c, 8'h00);
    host_u.write_reg(7'h11, REG_PROG_N, 8'h55, ok);
    `CHK("nak", 1'b0, ok)
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      reg_wr(REG_PROG_N, r[7:0]);
      reg_wr(REG_PROG_M, r[15:8]);
      reg_wr(REG_PROG_N, r[23:16]);
      reg_wr(REG_SEL, r[31:24]);
      reg_wr(REG_CTRL, {r[i], 7'h00});
      chk_outs();
      rd_chk(REG_PROG_N, r[23:16]);
    end
    wd_pulse();
    chk_outs();
    for (int k = 1; k >= 0; k--) begin
      r = $random(seed);
      reg_wr(REG_REC_N, r[7:0]);
      reg_wr(REG_REC_SEL_M, {k[0], r[14:8]});
      reg_wr(REG_CTRL, {r[24], 2'b00, k[0], 4'h2});
      wd_pulse();
      chk_outs();
      rd_chk(REG_CTRL, mr[4] | (flag << 2));
      reg_wr(REG_PROG_M, ~r[15:8]);
      reg_wr(REG_REC_N, ~r[7:0]);
      reg_wr(REG_SEL, ~r[31:24]);
      chk_outs();
      reg_wr(REG_CTRL, (mr[4] & 8'h80) | 8'h04);
      chk_outs();
    end
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end
endmodule
bind clk_freq_ctl clk_freq_ctl_asserts chk_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .watchdog_zero_i(watchdog_zero_i), .cpu_n_o(cpu_n_o), .cpu_m_o(cpu_m_o),
  .cpu_use_nm_o(cpu_use_nm_o), .cpu_table_sel_o(cpu_table_sel_o),
  .ratio_sel_o(ratio_sel_o), .freq_load_o(freq_load_o),
  .recovery_mode_o(recovery_mode_o), .system_reset_o(system_reset_o),
  .watchdog_enable_o(watchdog_enable_o),
  .watchdog_timeout_flag_o(watchdog_timeout_flag_o));
